// *** verilog/i2c_target_register_port.sv ***
// i2c target register port with paged byte registers and axi4-lite control
`timescale 1ns/1ps
module i2c_target_register_port
    import i2c_target_pkg::*;
(
    input  wire logic                     mclk,
    input  wire logic                     reset_n,
    input  wire logic                     sclIn,
    input  wire logic                     sdaIn,
    output logic                          sdaOut,
    output logic                          sdaOe,
    input  wire logic                     shutdownNPin,
    input  wire logic                     addrStrapHigh,
    input  wire logic                     addrStrapLow,
    input  wire i2c_target_pkg::axi_req_t axiReq,
    output i2c_target_pkg::axi_rsp_t      axiRsp
);
    import i2c_target_pkg::*;

    typedef struct packed {
        i2c_state_t  st;
        logic [2:0]  bitCnt;
        logic        byteDone;
        logic [7:0]  shift;
        logic        rw;
        logic [6:0]  ptr;
        logic [7:0]  page;
        logic [7:0]  writeChecksumValue;
        logic        sdaOe;
        logic        sdaOut;
        logic [6:0]  localAddr;
        logic        latchPend;
        logic        broadcastAddrEnable;
        logic [4:0]  sync1;
        logic [4:0]  sync2;
        logic        sclPrev;
        logic        sdaPrev;
        logic        shutPrev;
        logic        masterAck;
        logic        awHeld;
        logic [7:0]  awAddr;
        logic        wHeld;
        logic [31:0] wData;
        logic [3:0]  wStrb;
        axi_rsp_t    rsp;
    } state_t;

    logic [1:0]        rstSync;
    logic              rstN;
    state_t            r;
    state_t            n;
    logic [7:0]        mem [MEM_DEPTH];
    logic              memWe;
    logic [MEM_AW-1:0] memIdx;
    logic [7:0]        memWdata;
    logic              scl;
    logic              sda;
    logic              shut;
    logic              sclRise;
    logic              sclFall;
    logic              startDet;
    logic              stopDet;
    logic              noEvt;
    logic              swRst;
    logic              wrEvt;
    logic              addrHit;
    logic [6:0]        rdPtr;
    logic [7:0]        rdByte;

    // reset release through two flops
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            rstSync <= 2'h0;
        else
            rstSync <= {rstSync[0], 1'b1};
    end
    assign rstN = rstSync[1];

    // pin views and bus conditions, all from second sync flop
    assign scl      = r.sync2[PIN_SCL];
    assign sda      = r.sync2[PIN_SDA];
    assign shut     = r.sync2[PIN_SHUT];
    assign sclRise  = scl & ~r.sclPrev;
    assign sclFall  = ~scl & r.sclPrev;
    assign startDet = scl & r.sclPrev & r.sdaPrev & ~sda;
    assign stopDet  = scl & r.sclPrev & ~r.sdaPrev & sda;
    assign noEvt    = shut & ~startDet & ~stopDet;
    assign addrHit  = (r.shift[7:1] == r.localAddr)
                    | (r.broadcastAddrEnable & (r.shift[7:1] == BCAST_ADDR));

    // byte to send: current pointer, or next one when the host acked
    assign rdPtr  = (r.st == ST_RDATA_ACK) ? 7'(r.ptr + 7'h01) : r.ptr;
    assign rdByte = (rdPtr == PAGE_SEL_REG) ? r.page :
                    (rdPtr == CKSUM_REG)    ? r.writeChecksumValue :
                    mem[{r.page[PAGE_IDX_W-1:0], rdPtr}];

    // next-state logic
    always_comb
    begin
        n        = r;
        memWe    = 1'b0;
        memIdx   = {r.page[PAGE_IDX_W-1:0], r.ptr};
        memWdata = r.shift;
        swRst    = 1'b0;
        wrEvt    = 1'b0;
        n.sync1    = {addrStrapHigh, addrStrapLow, shutdownNPin, sdaIn, sclIn};
        n.sync2    = r.sync1;
        n.sclPrev  = scl;
        n.sdaPrev  = sda;
        n.shutPrev = shut;

        // axi4-lite write: address and data in either order
        if (axiReq.awvalid && r.rsp.awready)
        begin
            n.awHeld = 1'b1;
            n.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && r.rsp.wready)
        begin
            n.wHeld = 1'b1;
            n.wData = axiReq.wdata;
            n.wStrb = axiReq.wstrb;
        end
        if (r.awHeld && r.wHeld && !r.rsp.bvalid)
        begin
            n.awHeld     = 1'b0;
            n.wHeld      = 1'b0;
            n.rsp.bvalid = 1'b1;
            n.rsp.bresp  = RESP_OKAY;
            if (r.awAddr == CTRL_OFS)
            begin
                if (r.wStrb[0])
                begin
                    n.broadcastAddrEnable = r.wData[CTRL_BCAST_BIT];
                    swRst                 = r.wData[CTRL_SWRST_BIT];
                end
            end
            else if (r.awAddr != STATUS_OFS && r.awAddr != CKSUM_OFS)
                n.rsp.bresp = RESP_SLVERR;
        end
        else if (r.rsp.bvalid && axiReq.bready)
            n.rsp.bvalid = 1'b0;
        n.rsp.awready = ~n.awHeld & ~n.rsp.bvalid;
        n.rsp.wready  = ~n.wHeld & ~n.rsp.bvalid;

        // axi4-lite read
        if (axiReq.arvalid && r.rsp.arready)
        begin
            n.rsp.rvalid = 1'b1;
            n.rsp.rresp  = RESP_OKAY;
            unique case (axiReq.araddr)
                CTRL_OFS:   n.rsp.rdata = {31'h0, r.broadcastAddrEnable};
                STATUS_OFS: n.rsp.rdata = {15'h0, r.st != ST_IDLE, r.page, shut, r.localAddr};
                CKSUM_OFS:  n.rsp.rdata = {24'h0, r.writeChecksumValue};
                default:
                begin
                    n.rsp.rdata = 32'h0;
                    n.rsp.rresp = RESP_SLVERR;
                end
            endcase
        end
        else if (r.rsp.rvalid && axiReq.rready)
            n.rsp.rvalid = 1'b0;
        n.rsp.arready = ~n.rsp.rvalid;

        // strap capture after reset, shutdown release or software reset
        if (r.latchPend || (shut && !r.shutPrev) || swRst)
            n.localAddr = {LOCAL_ADDR_BASE[6:2], r.sync2[PIN_HI], r.sync2[PIN_LO]};
        n.latchPend = 1'b0;

        // i2c target sequencer
        if (!shut || stopDet)
        begin
            n.st    = ST_IDLE;
            n.sdaOe = 1'b0;
        end
        else if (startDet)
        begin
            n.st       = ST_ADDR;   // repeated start also ends a write burst
            n.bitCnt   = 3'h0;
            n.byteDone = 1'b0;
            n.sdaOe    = 1'b0;
        end
        else
        begin
            // msb-first shift of incoming bytes, no byte count limit
            if (sclRise && (r.st == ST_ADDR || r.st == ST_REG || r.st == ST_WDATA))
            begin
                n.shift  = {r.shift[6:0], sda};
                n.bitCnt = 3'(r.bitCnt + 3'h1);
                if (r.bitCnt == 3'h7)
                    n.byteDone = 1'b1;
            end
            unique case (r.st)
                ST_IDLE:;
                ST_ADDR, ST_REG, ST_WDATA:
                    if (sclFall && r.byteDone)
                    begin
                        n.byteDone = 1'b0;
                        n.sdaOe    = 1'b1;   // ack from this scl low to the next
                        if (r.st == ST_ADDR)
                        begin
                            n.rw    = r.shift[0];
                            n.st    = ST_ADDR_ACK;
                            n.sdaOe = addrHit;
                            if (!addrHit)
                                n.st = ST_IDLE;
                        end
                        else if (r.st == ST_REG)
                        begin
                            n.ptr = r.shift[6:0];
                            n.st  = ST_REG_ACK;
                        end
                        else
                        begin
                            wrEvt = 1'b1;
                            n.st  = ST_WDATA_ACK;
                            n.ptr = 7'(r.ptr + 7'h01);
                            if (r.ptr == PAGE_SEL_REG)
                                n.page = r.shift;
                            else if (r.ptr != CKSUM_REG)
                                memWe = 1'b1;
                            if (r.ptr == CKSUM_REG)
                                n.writeChecksumValue = r.shift;
                            else
                                n.writeChecksumValue = 8'(r.writeChecksumValue + r.shift);
                        end
                    end
                ST_ADDR_ACK:
                    if (sclFall)
                    begin
                        n.bitCnt = 3'h0;
                        if (r.rw)
                        begin
                            n.st    = ST_RDATA;
                            n.shift = rdByte;
                            n.sdaOe = ~rdByte[7];
                        end
                        else
                        begin
                            n.st    = ST_REG;
                            n.sdaOe = 1'b0;
                        end
                    end
                ST_REG_ACK, ST_WDATA_ACK:
                    if (sclFall)
                    begin
                        n.st     = ST_WDATA;
                        n.bitCnt = 3'h0;
                        n.sdaOe  = 1'b0;
                    end
                ST_RDATA:
                begin
                    if (sclRise)
                    begin
                        n.bitCnt = 3'(r.bitCnt + 3'h1);
                        if (r.bitCnt == 3'h7)
                            n.byteDone = 1'b1;
                    end
                    if (sclFall)
                    begin
                        if (r.byteDone)
                        begin
                            n.byteDone = 1'b0;
                            n.sdaOe    = 1'b0;   // leave sda to the host's ack
                            n.st       = ST_RDATA_ACK;
                        end
                        else
                        begin
                            n.shift = {r.shift[6:0], 1'b0};
                            n.sdaOe = ~r.shift[6];
                        end
                    end
                end
                ST_RDATA_ACK:
                begin
                    if (sclRise)
                        n.masterAck = ~sda;
                    if (sclFall)
                    begin
                        n.bitCnt = 3'h0;
                        if (r.masterAck)
                        begin
                            n.st    = ST_RDATA;
                            n.ptr   = rdPtr;
                            n.shift = rdByte;
                            n.sdaOe = ~rdByte[7];
                        end
                        else
                            n.st = ST_IDLE;   // host nack ends the read
                    end
                end
            endcase
        end

        if (swRst)
        begin
            n.page               = PAGE_RST;
            n.writeChecksumValue = CKSUM_RST;
        end
    end

    // state register
    always_ff @(posedge mclk or negedge rstN)
    begin
        if (!rstN)
        begin
            r                     <= '0;
            r.localAddr           <= LOCAL_ADDR_BASE;
            r.latchPend           <= 1'b1;
            r.broadcastAddrEnable <= BCAST_EN_RST;
            r.rsp.awready         <= 1'b1;
            r.rsp.wready          <= 1'b1;
            r.rsp.arready         <= 1'b1;
        end
        else
            r <= n;
    end

    // register storage, no reset
    always_ff @(posedge mclk)
    begin
        if (memWe)
            mem[memIdx] <= memWdata;
    end

    assign sdaOut = r.sdaOut;
    assign sdaOe  = r.sdaOe;
    assign axiRsp = r.rsp;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstN);

    chk_strap_latch: assert property ($rose(shut) |=> r.localAddr[1:0] == $past(r.sync2[PIN_HI:PIN_LO]))
        else $error("strap levels not latched on shutdown release");
    chk_local_base: assert property (r.localAddr[6:2] == LOCAL_ADDR_BASE[6:2])
        else $error("local address outside strap range");
    chk_bcast_gate: assert property ((r.st == ST_ADDR) && sclFall && r.byteDone && noEvt
        && !r.broadcastAddrEnable && (r.shift[7:1] == BCAST_ADDR) |=> (r.st == ST_IDLE) && !r.sdaOe)
        else $error("broadcast address acked while disabled");
    chk_ack_hold: assert property (r.st inside {ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK} |-> r.sdaOe)
        else $error("sda released during acknowledge");
    chk_drive_scl_low: assert property ($rose(r.sdaOe) |-> $past(sclFall) && !scl)
        else $error("sda driven outside scl low");
    chk_write_incr: assert property (wrEvt |=> r.ptr == 7'($past(r.ptr) + 7'h01) ##0 r.st == ST_WDATA_ACK)
        else $error("write pointer did not advance");
    chk_read_next: assert property ((r.st == ST_RDATA_ACK) && sclFall && r.masterAck && noEvt
        |=> (r.st == ST_RDATA) && (r.ptr == 7'($past(r.ptr) + 7'h01)))
        else $error("read did not continue at next register");
    chk_burst_go_on: assert property ((r.st == ST_WDATA_ACK) && sclFall && noEvt |=> r.st == ST_WDATA)
        else $error("write burst cut short");
    chk_page_reset: assert property (swRst |=> (r.page == PAGE_RST) && (r.writeChecksumValue == CKSUM_RST))
        else $error("software reset left page or checksum");
    chk_cksum_sum: assert property (wrEvt && (r.ptr != CKSUM_REG) && !swRst
        |=> r.writeChecksumValue == 8'($past(r.writeChecksumValue) + $past(r.shift)))
        else $error("checksum not accumulated");
    chk_axi_bresp: assert property (r.awHeld && r.wHeld && !r.rsp.bvalid |=> r.rsp.bvalid ##1 !r.awHeld)
        else $error("write response missing");

    cov_read_burst: cover property ((r.st == ST_RDATA_ACK) && sclFall && r.masterAck ##[1:1000] r.st == ST_RDATA_ACK);
    cov_bcast_write: cover property ((r.st == ST_ADDR) && sclFall && r.byteDone && noEvt
        && r.broadcastAddrEnable && (r.shift[7:1] == BCAST_ADDR));
    cov_sw_reset: cover property (swRst);

endmodule : i2c_target_register_port

// *** verilog/i2c_target_pkg.sv ***
// constants, types and bus carriers for the i2c target register port
package i2c_target_pkg;

    // register space: pages of 128 byte registers, a few pages backed by storage
    localparam int PAGE_REGS  = 128;
    localparam int PAGE_IDX_W = 2;
    localparam int MEM_DEPTH  = PAGE_REGS * (1 << PAGE_IDX_W);
    localparam int MEM_AW     = 9;

    // i2c addressing (7-bit form)
    localparam logic [6:0] LOCAL_ADDR_BASE = 7'h48;   // 8-bit form 0x90
    localparam logic [6:0] BCAST_ADDR      = 7'h40;   // 8-bit form 0x80
    localparam logic       BCAST_EN_RST    = 1'b1;

    // special registers inside every page
    localparam logic [6:0] PAGE_SEL_REG = 7'h00;
    localparam logic [6:0] CKSUM_REG    = 7'h7F;
    localparam logic [7:0] PAGE_RST     = 8'h00;
    localparam logic [7:0] CKSUM_RST    = 8'h00;

    // synchronised pin vector positions
    localparam int PIN_SCL  = 0;
    localparam int PIN_SDA  = 1;
    localparam int PIN_SHUT = 2;
    localparam int PIN_LO   = 3;
    localparam int PIN_HI   = 4;

    // axi4-lite map
    localparam int         AXI_AW         = 8;
    localparam logic [7:0] CTRL_OFS       = 8'h00;
    localparam logic [7:0] STATUS_OFS     = 8'h04;
    localparam logic [7:0] CKSUM_OFS      = 8'h08;
    localparam int         CTRL_BCAST_BIT = 0;
    localparam int         CTRL_SWRST_BIT = 1;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
    } i2c_state_t;

    typedef struct packed {
        logic              awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [AXI_AW-1:0] araddr;
        logic              rready;
    } axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_rsp_t;

endpackage : i2c_target_pkg

// *** dv/i2c_host_model.sv ***
// behavioural i2c host controller on an open-drain bus
`timescale 1ns/1ps
module i2c_host_model (
    input  wire logic mclk,
    input  wire logic sdaOe,
    output logic      sclIn,
    output logic      sdaIn
);
    int   q      = 20;
    logic sclDrv = 1'b1;
    logic sdaDrv = 1'b1;
    // wired-and lines, pull-ups give the released level
    assign sclIn = sclDrv;
    assign sdaIn = sdaDrv & ~sdaOe;
    // wait n quarter bit periods
    task automatic wq(input int n);
        repeat (n * q) @(posedge mclk);
    endtask : wq
    // one bit: data moves while scl low, sampled mid high
    task automatic bitIo(input logic b, output logic s);
        sdaDrv <= b;
        wq(1);
        sclDrv <= 1'b1;
        wq(1);
        s = sdaIn;
        wq(1);
        sclDrv <= 1'b0;
        wq(1);
    endtask : bitIo
    // start or repeated start: sda falls while scl high
    task automatic startCond();
        sdaDrv <= 1'b1;
        wq(1);
        sclDrv <= 1'b1;
        wq(1);
        sdaDrv <= 1'b0;
        wq(1);
        sclDrv <= 1'b0;
        wq(1);
    endtask : startCond
    // stop: sda rises while scl high
    task automatic stopCond();
        sdaDrv <= 1'b0;
        wq(1);
        sclDrv <= 1'b1;
        wq(1);
        sdaDrv <= 1'b1;
        wq(2);
    endtask : stopCond
    // byte msb first, then the target's acknowledge slot
    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitIo(d[i], s);
        bitIo(1'b1, s);
        ack = ~s;
    endtask : sendByte
    // byte from the target, acknowledged unless it is the last
    task automatic recvByte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bitIo(1'b1, d[i]);
        bitIo(last, s);
    endtask : recvByte
endmodule : i2c_host_model

// *** dv/i2c_target_register_port_tb.sv ***
// self-checking bench for the i2c target register port
`timescale 1ns/1ps
module i2c_target_register_port_tb;
    import i2c_target_pkg::*;
    logic        mclk     = 1'b0;
    logic        reset_n  = 1'b0;
    logic        shutN    = 1'b1;
    logic [1:0]  strap    = 2'b00;
    axi_req_t    req      = '0;
    axi_rsp_t    rsp;
    logic        sclIn;
    logic        sdaIn;
    logic        sdaOut;
    logic        sdaOe;
    int          errCount = 0;
    int          nTests   = 0;
    logic [7:0]  wd [4];
    logic [7:0]  ed [4];
    // device and host
    i2c_target_register_port uut (.mclk(mclk), .reset_n(reset_n), .sclIn(sclIn), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .shutdownNPin(shutN), .addrStrapHigh(strap[1]),
        .addrStrapLow(strap[0]), .axiReq(req), .axiRsp(rsp));
    i2c_host_model host (.mclk(mclk), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));
    // 250 mhz clock
    initial
    begin
        forever #2 mclk = ~mclk;
    end
    // compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            errCount++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // verdict and end of run
    task automatic stopTest();
        if (errCount == 0 && nTests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stopTest
    // axi4-lite write, address and data offered together
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        @(posedge mclk);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= v;
        req.wstrb   <= 4'hF;
        req.bready  <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        req.bready <= 1'b0;
        check("bresp", rsp.bresp, er);
    endtask : axiWrite
    // axi4-lite read compared under a mask
    task automatic axiCheck(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ev,
                            input logic [1:0] er);
        @(posedge mclk);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        req.rready <= 1'b0;
        check("rdata", rsp.rdata & m, ev);
        check("rresp", rsp.rresp, er);
    endtask : axiCheck
    // i2c write of n bytes from wd starting at register rg
    task automatic i2cWrite(input logic [6:0] dev, input logic [7:0] rg, input int n, input logic ea);
        logic a;
        host.startCond();
        host.sendByte({dev, 1'b0}, a);
        check("addr ack", a, ea);
        check("sda drive level", sdaOut, 32'h0);
        if (a === 1'b1)
        begin
            host.sendByte(rg, a);
            check("reg ack", a, 1'b1);
            for (int i = 0; i < n; i++)
            begin
                host.sendByte(wd[i], a);
                check("data ack", a, 1'b1);
            end
        end
        host.stopCond();
    endtask : i2cWrite
    // i2c read of n bytes from rg, compared with ed
    task automatic i2cRead(input logic [6:0] dev, input logic [7:0] rg, input int n);
        logic       a;
        logic [7:0] v;
        host.startCond();
        host.sendByte({dev, 1'b0}, a);
        host.sendByte(rg, a);
        host.startCond();
        host.sendByte({dev, 1'b1}, a);
        check("read addr ack", a, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            host.recvByte(i == n - 1, v);
            check("read data", v, ed[i]);
        end
        host.stopCond();
    endtask : i2cRead
    // watchdog
    initial
    begin
        repeat (80000) @(posedge mclk);
        errCount++;
        stopTest();
    end
    // main sequence
    initial
    begin
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (10) @(posedge mclk);
        axiCheck(CTRL_OFS, 32'h3, 32'h1, RESP_OKAY);
        axiCheck(STATUS_OFS, 32'hFFFF, 32'hC8, RESP_OKAY);
        for (int s = 0; s < 4; s++)
        begin
            strap <= 2'(s);
            shutN <= 1'b0;
            repeat (8) @(posedge mclk);
            if (s == 0) i2cWrite(LOCAL_ADDR_BASE, 8'h10, 0, 1'b0);
            shutN <= 1'b1;
            repeat (8) @(posedge mclk);
            axiCheck(STATUS_OFS, 32'h7F, 32'(LOCAL_ADDR_BASE + 7'(s)), RESP_OKAY);
            i2cWrite(LOCAL_ADDR_BASE + 7'(s), 8'h10, 0, 1'b1);
            i2cWrite(LOCAL_ADDR_BASE + 7'((s + 1) % 4), 8'h10, 0, 1'b0);
        end
        strap <= 2'b00;
        repeat (8) @(posedge mclk);
        axiCheck(STATUS_OFS, 32'h7F, 32'h4B, RESP_OKAY);
        axiWrite(CTRL_OFS, 32'h3, RESP_OKAY);
        repeat (8) @(posedge mclk);
        axiCheck(STATUS_OFS, 32'hFF7F, 32'h48, RESP_OKAY);
        axiCheck(CTRL_OFS, 32'h3, 32'h1, RESP_OKAY);
        wd = '{8'h11, 8'h22, 8'h33, 8'h44};
        i2cWrite(LOCAL_ADDR_BASE, 8'h10, 4, 1'b1);
        axiCheck(CKSUM_OFS, 32'hFF, 32'hAA, RESP_OKAY);
        ed = '{8'h11, 8'h22, 8'h33, 8'h44};
        i2cRead(LOCAL_ADDR_BASE, 8'h10, 4);
        ed[0] = 8'hAA;
        i2cRead(LOCAL_ADDR_BASE, {1'b0, CKSUM_REG}, 1);
        wd[0] = 8'hA5;
        i2cWrite(BCAST_ADDR, 8'h20, 1, 1'b1);
        axiWrite(CTRL_OFS, 32'h0, RESP_OKAY);
        axiCheck(CTRL_OFS, 32'h1, 32'h0, RESP_OKAY);
        wd[0] = 8'h3C;
        i2cWrite(BCAST_ADDR, 8'h20, 1, 1'b0);
        ed[0] = 8'hA5;
        i2cRead(LOCAL_ADDR_BASE, 8'h20, 1);
        axiCheck(CKSUM_OFS, 32'hFF, 32'h4F, RESP_OKAY);
        wd[0] = 8'h01;
        i2cWrite(LOCAL_ADDR_BASE, 8'h00, 1, 1'b1);
        axiCheck(STATUS_OFS, 32'hFF00, 32'h100, RESP_OKAY);
        host.q = 63;
        wd[0] = 8'h5A;
        i2cWrite(LOCAL_ADDR_BASE, 8'h10, 1, 1'b1);
        host.q = 20;
        ed[0] = 8'h5A;
        i2cRead(LOCAL_ADDR_BASE, 8'h10, 1);
        wd[0] = 8'h00;
        i2cWrite(LOCAL_ADDR_BASE, 8'h00, 1, 1'b1);
        ed[0] = 8'h11;
        i2cRead(LOCAL_ADDR_BASE, 8'h10, 1);
        axiWrite(CKSUM_OFS, 32'h0, RESP_OKAY);
        axiCheck(CKSUM_OFS, 32'hFF, 32'hAA, RESP_OKAY);
        axiWrite(8'h0C, 32'h1, RESP_SLVERR);
        axiCheck(8'h0C, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
        stopTest();
    end
endmodule : i2c_target_register_port_tb
